// ---- inc/wfw_consts.svh ----
// Purpose: Register offsets, field positions, key values and reset values.
// Assumes: APB byte addressing, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef WFW_CONSTS_SVH
`define WFW_CONSTS_SVH
`define WFW_OFF_CONTROL   12'h000
`define WFW_OFF_PRECLEAR  12'h004
`define WFW_OFF_CLEAR     12'h008
`define WFW_OFF_STATUS    12'h00C
`define WFW_OFF_CNT_LO    12'h010
`define WFW_OFF_CNT_HI    12'h014
`define WFW_OFF_HOLD      12'h018
`define WFW_OFF_TMO_LO    12'h01C
`define WFW_OFF_TMO_HI    12'h020
`define WFW_OFF_IVL_LO    12'h024
`define WFW_OFF_IVL_HI    12'h028
`define WFW_ON_BIT        15
`define WFW_ST_ERR1_BIT   7
`define WFW_ST_ERR2_BIT   6
`define WFW_ST_EVT_BIT    5
`define WFW_ST_WIN_BIT    0
`define WFW_KEY1          8'h40
`define WFW_KEY2          8'h08
`define WFW_HALF_RESET    16'h0000
`define WFW_KEY_RESET     8'h00
`endif

// ---- inc/wfw_pkg.sv ----
// Purpose: Types shared by the watchdog modules.
// Assumes: Nothing beyond the constants header.
// Notes:   One-hot key sequence states.
package wfw_pkg;
  typedef enum logic [2:0]
  {
    WFW_IDLE  = 3'b001,
    WFW_ARMED = 3'b010,
    WFW_DEAD  = 3'b100
  } wfw_seq_t;
endpackage

// ---- inc/wfw_cnt_if.sv ----
// Purpose: Signals between the top and the fetch counter.
// Assumes: One clock domain.
// Notes:   The top drives control, the counter returns its value.
`timescale 1ns/100ps
`default_nettype none
interface wfw_cnt_if;
  logic        run;
  logic        clr;
  logic [31:0] limit;
  logic [31:0] value;
  logic        match;
  modport ctl (output run, output clr, output limit,
               input value, input match);
  modport cnt (input run, input clr, input limit,
               output value, output match);
endinterface
`default_nettype wire

// ---- design/wfw_counter.sv ----
// Purpose: 32-bit fetch counter that stops on the time-out match.
// Assumes: run is one cycle per instruction fetch while enabled and awake.
// Notes:   A clear has priority over counting.
`timescale 1ns/100ps
`default_nettype none
module wfw_counter
  import wfw_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  wfw_cnt_if.cnt    cbus
);
  logic [31:0] count_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= 32'h0000_0000;
    else if (cbus.clr)
      count_reg <= 32'h0000_0000;
    else if (cbus.run && (count_reg != cbus.limit)) // see R8
      count_reg <= count_reg + 32'h0000_0001;
  end

  assign cbus.value = count_reg;
  assign cbus.match = (count_reg == cbus.limit); // see R9

  stop_at_match_a: assert property ( // see R8
    @(posedge pclk) disable iff (!presetn)
    cbus.match && !cbus.clr |=> $stable(count_reg))
    else $error("Counter moved after the time-out match.");
  count_idle_a: assert property ( // see R13
    @(posedge pclk) disable iff (!presetn)
    !cbus.run && !cbus.clr |=> $stable(count_reg))
    else $error("Counter moved without a fetch.");
endmodule // wfw_counter
`default_nettype wire

// ---- design/wfw_hold.sv ----
// Purpose: Upper-count hold register loaded on counter reads.
// Assumes: load is a one-cycle pulse on an accepted counter read.
// Notes:   Holds its value otherwise.
`timescale 1ns/100ps
`default_nettype none
`include "wfw_consts.svh"
module wfw_hold
  import wfw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] upper,
  output var  logic [15:0] hold
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold <= `WFW_HALF_RESET; // see R7
    else if (load)
      hold <= upper; // see R7
  end

  hold_stable_a: assert property ( // see R7
    @(posedge pclk) disable iff (!presetn)
    !load |=> $stable(hold))
    else $error("Hold register changed without a counter read.");
endmodule // wfw_hold
`default_nettype wire

// ---- design/wfw_top.sv ----
// Purpose: Windowed instruction-fetch watchdog with an APB register port.
// Assumes: fetch_strobe, sleep_mode and fuse inputs are synchronous to pclk.
// Notes:   The event output is a level held until reset.
// Behaviour
// R1: Event flag sets on expiry or on a wrong first or second key.
// R2: Status bit 0 reads one while the clear window is open.
// R3: Key error and event flags clear only on reset.
// R4: The 32-bit counter is readable, not writable, as two halves.
// R5: Time-out mirrors always return the fuse time-out halves.
// R6: Interval mirrors always return the fuse interval halves.
// R7: Hold register resets to 0, loads the upper half on counter reads.
// R8: Counter increments per fetch and stops at the match.
// R9: Counter matching the time-out raises the watchdog event.
// R10: Fuse enable keeps the watchdog on; the enable bit reads 1.
// R11: Without the fuse, software may enable it and never disable it.
// R12: Clear allowed only when count reaches the interval; early clear is an event.
// R13: Counter holds while the core sleeps or idles.
// R14: First key must be 0x40; others set first-key error and event.
// R15: Second key without a valid first key sets first-key error and event.
// R16: Software writes 0x08 only after a valid first key in the window.
// R17: A valid sequence clears counter, key registers and status; the key error and event flags stay set.
// R18: A second key other than 0x08 sets second-key error and event.
// R19: A second key outside the window sets second-key error and event.
// R20: Two first-key writes in a row set second-key error and event.
// R21: Error flags take two cycles, the event flag three.
// R22: After expiry or key error only a reset clears the counter; a wrong first key while armed still lets a valid clear through.
// R23: Writing zero to the enable bit is ignored.
// R24: A bad second key keeps the first key and captures the new value.
// R25: The event output stays high from the event until reset.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "wfw_consts.svh"
module wfw_top
  import wfw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        fetch_strobe,
  input  wire logic        sleep_mode,
  input  wire logic        fuse_enable,
  input  wire logic [15:0] timeout_fuse_low,
  input  wire logic [15:0] timeout_fuse_high,
  input  wire logic [15:0] interval_fuse_low,
  input  wire logic [15:0] interval_fuse_high,
  output var  logic        watchdog_event
);
  ////////////////////////////////////////////////////////////////////////////
  wfw_cnt_if   cbus ();
  wfw_seq_t    seq_reg;
  logic        sw_on_reg;
  logic [7:0]  first_key_reg;
  logic [7:0]  second_key_reg;
  logic        first_key_error;
  logic        second_key_error;
  logic        watchdog_event_flag;
  logic        err1_p1_reg;
  logic        err2_p1_reg;
  logic        evt_p1_reg;
  logic        evt_p2_reg;
  logic [15:0] upper_count_hold;
  logic        enabled;
  logic        clear_window_open;
  logic [31:0] window_interval_value;
  logic        wr_acc;
  logic        rd_acc;
  logic        wr_pre;
  logic        wr_clr;
  logic        key1_ok;
  logic        key2_ok;
  logic        good_clear;
  logic        err1_now;
  logic        err2_now;
  logic        expired;
  logic        addr_ok;
  logic [31:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  assign window_interval_value = {interval_fuse_high, interval_fuse_low};
  assign enabled      = fuse_enable | sw_on_reg; // see R10
  assign wr_acc       = psel & penable & pwrite & pready;
  assign rd_acc       = psel & penable & ~pwrite & pready;
  assign wr_pre       = wr_acc && (paddr == `WFW_OFF_PRECLEAR);
  assign wr_clr       = wr_acc && (paddr == `WFW_OFF_CLEAR);
  assign key1_ok      = (pwdata[15:8] == `WFW_KEY1);
  assign key2_ok      = (pwdata[7:0] == `WFW_KEY2);
  assign clear_window_open = (cbus.value >= window_interval_value); // see R12
  assign expired      = enabled & cbus.match;
  // A wrong first key, or a second key with no first key before it.
  assign err1_now = (seq_reg != WFW_DEAD) &&
                    ((wr_pre && !key1_ok) || // see R14
                     (wr_clr && seq_reg == WFW_IDLE)); // see R15
  // Repeat first key, wrong second key, or second key outside the window.
  assign err2_now = (seq_reg == WFW_ARMED) &&
                    ((wr_pre && key1_ok) || // see R20
                     (wr_clr && !key2_ok) || // see R18
                     (wr_clr && !clear_window_open)); // see R12 R19
  assign good_clear = (seq_reg == WFW_ARMED) && wr_clr && key2_ok &&
                      clear_window_open && !expired; // see R16 R22

  ////////////////////////////////////////////////////////////////////////////
  assign cbus.run   = enabled & fetch_strobe & ~sleep_mode; // see R8 R13
  assign cbus.clr   = good_clear; // see R17
  assign cbus.limit = {timeout_fuse_high, timeout_fuse_low};

  wfw_counter u_counter
  (
    .pclk    (pclk),
    .presetn (presetn),
    .cbus    (cbus)
  );

  wfw_hold u_hold
  (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (rd_acc && (paddr == `WFW_OFF_CNT_LO ||
                         paddr == `WFW_OFF_CNT_HI)), // see R7
    .upper   (cbus.value[31:16]),
    .hold    (upper_count_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Software enable is sticky; a zero write never clears it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_on_reg <= 1'b0;
    else if (wr_acc && paddr == `WFW_OFF_CONTROL && pwdata[`WFW_ON_BIT])
      sw_on_reg <= 1'b1; // see R11 R23
  end

  // Key sequence; the dead state blocks any further clear until reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq_reg <= WFW_IDLE;
    else
    begin
      case (seq_reg)
        WFW_IDLE:
        begin
          if (expired || err1_now)
            seq_reg <= WFW_DEAD; // see R22
          else if (wr_pre && key1_ok)
            seq_reg <= WFW_ARMED;
        end
        WFW_ARMED:
        begin
          if (expired || err2_now)
            seq_reg <= WFW_DEAD; // see R22
          else if (good_clear)
            seq_reg <= WFW_IDLE;
        end
        WFW_DEAD:
          seq_reg <= WFW_DEAD;
        default:
          seq_reg <= WFW_DEAD;
      endcase
    end
  end

  // Key registers keep what software wrote, except a first key written while armed, until a good sequence clears them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_key_reg  <= `WFW_KEY_RESET;
      second_key_reg <= `WFW_KEY_RESET;
    end
    else if (good_clear)
    begin
      first_key_reg  <= `WFW_KEY_RESET; // see R17
      second_key_reg <= `WFW_KEY_RESET;
    end
    else
    begin
      if (wr_pre && seq_reg != WFW_ARMED)
        first_key_reg <= pwdata[15:8];
      if (wr_clr)
        second_key_reg <= pwdata[7:0]; // see R24
    end
  end

  // Errors land two cycles after the write and the event three, as allowed.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err1_p1_reg <= 1'b0;
      err2_p1_reg <= 1'b0;
      evt_p1_reg  <= 1'b0;
      evt_p2_reg  <= 1'b0;
    end
    else
    begin
      err1_p1_reg <= err1_now; // see R21
      err2_p1_reg <= err2_now;
      evt_p1_reg  <= err1_now | err2_now;
      evt_p2_reg  <= evt_p1_reg;
    end
  end

  // Sticky flags; nothing but reset clears them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_key_error     <= 1'b0;
      second_key_error    <= 1'b0;
      watchdog_event_flag <= 1'b0;
      watchdog_event      <= 1'b0;
    end
    else
    begin
      if (err1_p1_reg)
        first_key_error <= 1'b1; // see R3 R14 R15
      if (err2_p1_reg)
        second_key_error <= 1'b1; // see R3 R18 R19 R20
      if (evt_p2_reg || expired)
        watchdog_event_flag <= 1'b1; // see R1 R9
      if (evt_p2_reg || expired)
        watchdog_event <= 1'b1; // see R25
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-wait APB slave; unmapped addresses answer with pslverr.
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    addr_ok    = 1'b1;
    case (paddr)
      `WFW_OFF_CONTROL:  rdata_next[`WFW_ON_BIT] = enabled; // see R10
      `WFW_OFF_PRECLEAR: rdata_next[15:8] = first_key_reg;
      `WFW_OFF_CLEAR:    rdata_next[7:0]  = second_key_reg;
      `WFW_OFF_STATUS:
      begin
        rdata_next[`WFW_ST_ERR1_BIT] = first_key_error;
        rdata_next[`WFW_ST_ERR2_BIT] = second_key_error;
        rdata_next[`WFW_ST_EVT_BIT]  = watchdog_event_flag;
        rdata_next[`WFW_ST_WIN_BIT]  = clear_window_open; // see R2
      end
      `WFW_OFF_CNT_LO:   rdata_next[15:0] = cbus.value[15:0]; // see R4
      `WFW_OFF_CNT_HI:   rdata_next[15:0] = cbus.value[31:16];
      `WFW_OFF_HOLD:     rdata_next[15:0] = upper_count_hold;
      `WFW_OFF_TMO_LO:   rdata_next[15:0] = timeout_fuse_low; // see R5
      `WFW_OFF_TMO_HI:   rdata_next[15:0] = timeout_fuse_high;
      `WFW_OFF_IVL_LO:   rdata_next[15:0] = interval_fuse_low; // see R6
      `WFW_OFF_IVL_HI:   rdata_next[15:0] = interval_fuse_high;
      default:           addr_ok = 1'b0;
    endcase
  end

  // Read data is registered in the setup cycle so it stands in the access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (psel && !penable && !pwrite)
        prdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  err_delay_a: assert property ( // see R21
    @(posedge pclk) disable iff (!presetn)
    err1_now |-> ##2 first_key_error)
    else $error("First-key error not set two cycles after a bad write.");
  evt_delay_a: assert property ( // see R21
    @(posedge pclk) disable iff (!presetn)
    err2_now |-> ##3 (watchdog_event_flag && second_key_error))
    else $error("Event not set three cycles after a bad second key.");
  err1_event_a: assert property ( // see R1
    @(posedge pclk) disable iff (!presetn)
    err1_now |-> ##3 (watchdog_event_flag && watchdog_event))
    else $error("Bad first key did not raise the event.");
  flags_sticky_a: assert property ( // see R3
    @(posedge pclk) disable iff (!presetn)
    first_key_error |=> first_key_error)
    else $error("First-key error flag dropped without reset.");
  err2_sticky_a: assert property ( // see R3
    @(posedge pclk) disable iff (!presetn)
    second_key_error |=> second_key_error)
    else $error("Second-key error flag dropped without reset.");
  evt_sticky_a: assert property ( // see R3
    @(posedge pclk) disable iff (!presetn)
    watchdog_event_flag |=> watchdog_event_flag)
    else $error("Event flag dropped without reset.");
  event_level_a: assert property ( // see R25
    @(posedge pclk) disable iff (!presetn)
    watchdog_event |=> watchdog_event)
    else $error("Event output dropped without reset.");
  expiry_event_a: assert property ( // see R9
    @(posedge pclk) disable iff (!presetn)
    expired |=> watchdog_event_flag && watchdog_event)
    else $error("Counter match did not raise the event.");
  enable_sticky_a: assert property ( // see R11
    @(posedge pclk) disable iff (!presetn)
    sw_on_reg |=> sw_on_reg)
    else $error("Software enable was cleared.");
  fuse_on_read_a: assert property ( // see R10
    @(posedge pclk) disable iff (!presetn)
    fuse_enable && rd_acc && paddr == `WFW_OFF_CONTROL
      |-> prdata[`WFW_ON_BIT])
    else $error("Enable bit read zero with the fuse set.");
  window_read_a: assert property ( // see R2
    @(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `WFW_OFF_STATUS
      |-> prdata[`WFW_ST_WIN_BIT] == $past(clear_window_open))
    else $error("Status window bit did not follow the window.");
  good_clear_a: assert property ( // see R17
    @(posedge pclk) disable iff (!presetn)
    good_clear |=> cbus.value == 32'h0000_0000 &&
      first_key_reg == `WFW_KEY_RESET && second_key_reg == `WFW_KEY_RESET)
    else $error("Good sequence left the counter or a key standing.");
  key_capture_a: assert property ( // see R24
    @(posedge pclk) disable iff (!presetn)
    wr_clr && seq_reg == WFW_ARMED && !key2_ok |=>
      first_key_reg == $past(first_key_reg) &&
      second_key_reg == $past(pwdata[7:0]))
    else $error("Bad second key lost the first key or the new value.");
  no_clear_dead_a: assert property ( // see R22
    @(posedge pclk) disable iff (!presetn)
    seq_reg == WFW_DEAD |=> !cbus.clr && seq_reg == WFW_DEAD)
    else $error("Counter cleared after expiry or key error.");
  early_clear_a: assert property ( // see R12
    @(posedge pclk) disable iff (!presetn)
    wr_clr && seq_reg == WFW_ARMED && !clear_window_open
      |-> ##3 watchdog_event)
    else $error("Early clear did not raise the event.");
  early_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    wr_clr && seq_reg == WFW_ARMED && !clear_window_open);
  dead_write_c: cover property (@(posedge pclk) disable iff (!presetn)
    seq_reg == WFW_DEAD && wr_pre);
  good_seq_c: cover property (@(posedge pclk) disable iff (!presetn)
    good_clear);
  expiry_c: cover property (@(posedge pclk) disable iff (!presetn)
    expired);
  double_key_c: cover property (@(posedge pclk) disable iff (!presetn)
    wr_pre && key1_ok && seq_reg == WFW_ARMED);
endmodule // wfw_top
`default_nettype wire

// ---- dv/wfw_core_model.sv ----
// Purpose: Core fetch path that feeds the watchdog.
// Assumes: One pclk domain; the bench asks for fetches and sleep.
// Notes:   A sleeping core fetches nothing unless leak is commanded.
`timescale 1ns/100ps
`default_nettype none
module wfw_core_model
(
  input  wire logic pclk,
  input  wire logic want,
  input  wire logic asleep,
  input  wire logic leak,
  output var  logic fetch_strobe,
  output var  logic sleep_mode
);
  initial
  begin
    fetch_strobe = 1'b0;
    sleep_mode = 1'b0;
  end
  // Leak lets a scenario prove the block itself blocks counting.
  always @(posedge pclk)
  begin
    sleep_mode <= asleep;
    fetch_strobe <= want && (!asleep || leak);
  end
endmodule // wfw_core_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the fetch watchdog.
// Assumes: Zero-wait APB slave; fuses stay put between resets.
// Notes:   Each scenario has its own reset, since flags are sticky.
`timescale 1ns/100ps
`default_nettype none
`include "wfw_consts.svh"
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, fen = 1'b0, cnt_on = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        want = 1'b0, asleep = 1'b0, leak = 1'b0;
  logic        pready, pslverr, err_v, fetch_strobe, sleep_mode, ev;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, tmo_v = 32'h0000_0000;
  logic [31:0] ivl_v = 32'h0000_0000, prdata, rd_v, exp_cnt, k;
  logic [31:0] seed = 32'h0000_3650;
  int          failures = 0, samples_checked = 0;
  localparam logic [31:0] K1 = {16'h0000, `WFW_KEY1, 8'h00};
  localparam logic [31:0] K2 = {24'h00_0000, `WFW_KEY2};

  wfw_top wfw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_strobe(fetch_strobe), .sleep_mode(sleep_mode),
    .fuse_enable(fen), .timeout_fuse_low(tmo_v[15:0]),
    .timeout_fuse_high(tmo_v[31:16]), .interval_fuse_low(ivl_v[15:0]),
    .interval_fuse_high(ivl_v[31:16]), .watchdog_event(ev));
  wfw_core_model wfw_core_model_inst (.pclk(pclk), .want(want),
    .asleep(asleep), .leak(leak), .fetch_strobe(fetch_strobe),
    .sleep_mode(sleep_mode));

  always #10 pclk = ~pclk;
  // Expected count: awake fetches while enabled, frozen at the match.
  always @(posedge pclk)
    if (presetn && cnt_on && fetch_strobe && !sleep_mode && exp_cnt < tmo_v)
      exp_cnt <= exp_cnt + 32'h0000_0001;

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want_v);
    samples_checked++;
    if (seen !== want_v)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, want_v);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      finish_test();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd_v, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rst(input logic f, input logic [31:0] t,
                     input logic [31:0] i);
    fen <= f;
    cnt_on <= f;
    tmo_v <= t;
    ivl_v <= i;
    exp_cnt <= 32'h0000_0000;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic en();
    wr(`WFW_OFF_CONTROL, 32'h0000_0001 << `WFW_ON_BIT);
    cnt_on <= 1'b1;
  endtask

  // Mode 0 fetches every cycle, 1 random fetch and sleep, 2 leaky sleep.
  task automatic burst(input int n, input int mode);
    logic [31:0] r;
    repeat (n)
    begin
      r = xs();
      want <= (mode != 1) || r[0];
      asleep <= (mode == 2) || (mode == 1 && r[1] && r[2]);
      leak <= (mode == 2);
      @(posedge pclk);
    end
    want <= 1'b0;
    asleep <= 1'b0;
    leak <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // The event must show at the second edge after the bad access, not before.
  task automatic keyerr(input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] s);
    wr(a, d);
    @(posedge pclk);
    #1 check({31'h0000_0000, ev}, 32'h0000_0000);
    @(posedge pclk);
    #1 check({31'h0000_0000, ev}, 32'h0000_0001);
    rd(`WFW_OFF_STATUS, s);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    rst(1'b0, xs(), xs());
    rd(`WFW_OFF_TMO_LO, {16'h0000, tmo_v[15:0]});
    rd(`WFW_OFF_TMO_HI, {16'h0000, tmo_v[31:16]});
    rd(`WFW_OFF_IVL_LO, {16'h0000, ivl_v[15:0]});
    rd(`WFW_OFF_IVL_HI, {16'h0000, ivl_v[31:16]});
    rd(`WFW_OFF_HOLD, 32'h0000_0000);
    rd(`WFW_OFF_CONTROL, 32'h0000_0000);
    wr(`WFW_OFF_CNT_LO, xs());
    rd(`WFW_OFF_CNT_LO, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check({31'h0000_0000, err_v}, 32'h0000_0001);
    $display("test registers done");

    rst(1'b0, 32'h0001_0010, 32'h0001_0000);
    en();
    wr(`WFW_OFF_CONTROL, 32'h0000_0000);
    rd(`WFW_OFF_CONTROL, 32'h0000_8000);
    burst(300, 1);
    rd(`WFW_OFF_CNT_LO, {16'h0000, exp_cnt[15:0]});
    rd(`WFW_OFF_STATUS, 32'h0000_0000);
    burst(40, 2);
    rd(`WFW_OFF_CNT_LO, {16'h0000, exp_cnt[15:0]});
    burst(int'(ivl_v - exp_cnt) + 2, 0);
    rd(`WFW_OFF_CNT_HI, 32'h0000_0001);
    rd(`WFW_OFF_HOLD, 32'h0000_0001);
    rd(`WFW_OFF_CNT_LO, {16'h0000, exp_cnt[15:0]});
    rd(`WFW_OFF_STATUS, 32'h0000_0001);
    wr(`WFW_OFF_PRECLEAR, K1);
    wr(`WFW_OFF_CLEAR, K2);
    exp_cnt = 32'h0000_0000;
    rd(`WFW_OFF_HOLD, 32'h0000_0001);
    rd(`WFW_OFF_CNT_LO, 32'h0000_0000);
    rd(`WFW_OFF_PRECLEAR, 32'h0000_0000);
    rd(`WFW_OFF_CLEAR, 32'h0000_0000);
    rd(`WFW_OFF_STATUS, 32'h0000_0000);
    $display("test count and clear done");

    rst(1'b0, 32'h0000_0100, 32'h0000_0080);
    en();
    burst(20, 0);
    wr(`WFW_OFF_PRECLEAR, K1);
    keyerr(`WFW_OFF_CLEAR, K2, 32'h0000_0060);
    burst(int'(ivl_v), 0);
    wr(`WFW_OFF_PRECLEAR, K1);
    wr(`WFW_OFF_CLEAR, K2);
    rd(`WFW_OFF_CNT_LO, exp_cnt);
    rd(`WFW_OFF_STATUS, 32'h0000_0061);
    $display("test early clear done");

    for (int i = 0; i < 4; i++)
    begin
      rst(1'b0, 32'h0000_0100, 32'h0000_0000);
      en();
      k = xs();
      if (i >= 2)
        wr(`WFW_OFF_PRECLEAR, K1);
      case (i)
        0: keyerr(`WFW_OFF_PRECLEAR, {k[23:17], 1'b1} << 8, 32'h0000_00A1);
        1: keyerr(`WFW_OFF_CLEAR, K2, 32'h0000_00A1);
        2: keyerr(`WFW_OFF_PRECLEAR, K1, 32'h0000_0061);
        default:
        begin
          keyerr(`WFW_OFF_CLEAR, {k[7:1], 1'b1}, 32'h0000_0061);
          rd(`WFW_OFF_PRECLEAR, K1);
          rd(`WFW_OFF_CLEAR, {24'h00_0000, k[7:1], 1'b1});
        end
      endcase
    end
    $display("test key errors done");

    rst(1'b0, 32'h0000_0030, 32'h0000_0010);
    en();
    burst(64, 0);
    rd(`WFW_OFF_CNT_LO, 32'h0000_0030);
    check({31'h0000_0000, ev}, 32'h0000_0001);
    rd(`WFW_OFF_STATUS, 32'h0000_0021);
    wr(`WFW_OFF_PRECLEAR, K1);
    wr(`WFW_OFF_CLEAR, K2);
    burst(10, 0);
    rd(`WFW_OFF_CNT_LO, 32'h0000_0030);
    check({31'h0000_0000, ev}, 32'h0000_0001);
    $display("test expiry done");

    rst(1'b1, 32'h0000_0100, 32'h0000_0000);
    rd(`WFW_OFF_CONTROL, 32'h0000_8000);
    wr(`WFW_OFF_CONTROL, 32'h0000_0000);
    rd(`WFW_OFF_CONTROL, 32'h0000_8000);
    burst(10, 0);
    rd(`WFW_OFF_CNT_LO, 32'h0000_000A);
    $display("test fuse enable done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
